// ===== logic/cea_eeprom.sv
// two-wire serial calibration memory, slave side
module cea_eeprom #(
   parameter int WRITE_CYCLES = cea_pkg::WR_CYCLES
) (
   input  wire logic sys_clk,  // system clock
   input  wire logic rst_n,    // async reset, active low
   input  wire logic scl_in,   // bus clock pin
   input  wire logic sda_in,   // data pin level
   output logic      sda_out,  // data pin drive level
   output logic      sda_oe_n, // data pin pulled low when 0
   output logic      wr_busy   // internal write in progress
);
   localparam int WCW = cea_pkg::WR_CNT_W;
   localparam int HCW = cea_pkg::HOLD_CNT_W;
   localparam int AW  = cea_pkg::ADDR_W;

   logic [1:0]          pins_s;
   logic                scl_s;
   logic                sda_s;
   logic                scl_d;
   logic                sda_d;
   logic                scl_rise;
   logic                scl_fall;
   logic                start;
   logic                stop;
   cea_pkg::cea_bus_t   st;
   logic [3:0]          cnt;
   logic [7:0]          rx;
   logic [7:0]          tx;
   logic                dir_rd;
   logic [AW-1:0]       ptr;
   logic [7:0]          rd_byte;
   logic                rx_state;
   logic                rx_done;
   logic                tx_done;
   logic                ack_ok;
   logic                drive_low;
   logic [HCW-1:0]      hold_cnt;
   logic                wpush;
   logic                f_in_ready;
   logic                f_out_valid;
   logic                f_out_ready;
   logic [cea_pkg::FIFO_W-1:0] f_out_data;
   logic [7:0]          mem [cea_pkg::MEM_BYTES];
   logic [7:0]          pg_data [cea_pkg::PAGE_BYTES];
   logic [cea_pkg::PAGE_BYTES-1:0] pg_valid;
   logic [AW-cea_pkg::PAGE_W-1:0]  pg_high;
   logic                has_data;
   logic                commit_req;
   cea_pkg::cea_commit_t cstate;
   logic [3:0]          idx;
   logic [WCW-1:0]      wait_cnt;
   logic                busy;

   // drives low only, so the driven level is always zero
   assign sda_out = 1'b0;

   cea_sync #(
      .N (2)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       ({scl_in, sda_in}),
      .q       (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start    = scl_s && scl_d && sda_d && !sda_s;
   assign stop     = scl_s && scl_d && !sda_d && sda_s;

   assign rx_state = (st == cea_pkg::S_CTRL) || (st == cea_pkg::S_ADDR) ||
                     (st == cea_pkg::S_WDAT);
   assign rx_done  = rx_state && scl_fall && (cnt == cea_pkg::RX_LAST);
   assign tx_done  = (st == cea_pkg::S_TX) && scl_fall && (cnt == cea_pkg::TX_LAST);
   assign busy     = commit_req || (cstate != cea_pkg::C_IDLE);
   assign wr_busy  = busy;
   assign wpush    = rx_done && (st == cea_pkg::S_WDAT) && f_in_ready;

   // whether the byte just received earns an acknowledge
   always_comb begin
      ack_ok = 1'b0;
      unique case (st)
         cea_pkg::S_CTRL: ack_ok = (rx[cea_pkg::CODE_MSB:cea_pkg::CODE_LSB] ==
                                   cea_pkg::CTRL_CODE) && !busy;
         cea_pkg::S_ADDR: ack_ok = 1'b1;
         cea_pkg::S_WDAT: ack_ok = f_in_ready;
         cea_pkg::S_IDLE, cea_pkg::S_CACK, cea_pkg::S_AACK, cea_pkg::S_WACK,
         cea_pkg::S_TX, cea_pkg::S_MACK, cea_pkg::S_SKIP: ack_ok = 1'b0;
      endcase
   end

   // bus sequencer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st  <= cea_pkg::S_IDLE;
         cnt <= cea_pkg::CNT_RST;
      end else if (start) begin
         st  <= cea_pkg::S_CTRL;
         cnt <= cea_pkg::CNT_RST;
      end else if (stop) begin
         st  <= cea_pkg::S_IDLE;
         cnt <= cea_pkg::CNT_RST;
      end else begin
         unique case (st)
            cea_pkg::S_IDLE, cea_pkg::S_SKIP: begin
            end
            cea_pkg::S_CTRL, cea_pkg::S_ADDR, cea_pkg::S_WDAT: begin
               if (scl_rise && cnt != cea_pkg::RX_LAST) begin
                  cnt <= cnt + 4'h1;
               end
               if (rx_done) begin
                  cnt <= cea_pkg::CNT_RST;
                  if (!ack_ok) begin
                     st <= cea_pkg::S_SKIP;
                  end else if (st == cea_pkg::S_CTRL) begin
                     st <= cea_pkg::S_CACK;
                  end else if (st == cea_pkg::S_ADDR) begin
                     st <= cea_pkg::S_AACK;
                  end else begin
                     st <= cea_pkg::S_WACK;
                  end
               end
            end
            cea_pkg::S_CACK: begin
               if (scl_fall) begin
                  st <= dir_rd ? cea_pkg::S_TX : cea_pkg::S_ADDR;
               end
            end
            cea_pkg::S_AACK, cea_pkg::S_WACK: begin
               if (scl_fall) begin
                  st <= cea_pkg::S_WDAT;
               end
            end
            cea_pkg::S_TX: begin
               if (scl_fall) begin
                  if (cnt == cea_pkg::TX_LAST) begin
                     st  <= cea_pkg::S_MACK;
                     cnt <= cea_pkg::CNT_RST;
                  end else begin
                     cnt <= cnt + 4'h1;
                  end
               end
            end
            cea_pkg::S_MACK: begin
               if (scl_rise && sda_s) begin
                  st <= cea_pkg::S_SKIP;
               end else if (scl_fall) begin
                  st <= cea_pkg::S_TX;
               end
            end
         endcase
      end
   end

   // receive shifter and direction latch
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx     <= cea_pkg::BYTE_RST;
         dir_rd <= 1'b0;
      end else begin
         if (rx_state && scl_rise && cnt != cea_pkg::RX_LAST) begin
            rx <= {rx[6:0], sda_s};
         end
         if (rx_done && st == cea_pkg::S_CTRL) begin
            dir_rd <= rx[cea_pkg::DIR_BIT];
         end
      end
   end

   // transmit shifter, msb first
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx <= cea_pkg::BYTE_RST;
      end else if (scl_fall) begin
         if ((st == cea_pkg::S_CACK && dir_rd) || st == cea_pkg::S_MACK) begin
            tx <= rd_byte;
         end else if (st == cea_pkg::S_TX) begin
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   // address pointer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr <= cea_pkg::PTR_RST;
      end else if (rx_done && ack_ok && st == cea_pkg::S_ADDR) begin
         ptr <= {1'b0, rx};
      end else if (wpush) begin
         ptr[cea_pkg::PAGE_W-1:0] <= ptr[cea_pkg::PAGE_W-1:0] + 4'h1;
      end else if (tx_done) begin
         ptr <= ptr + 9'h001;
      end
   end

   // level wanted on the line after the next clock low hold
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_low <= 1'b0;
      end else if (start || stop) begin
         drive_low <= 1'b0;
      end else if (scl_fall) begin
         if (rx_done) begin
            drive_low <= ack_ok;
         end else if (st == cea_pkg::S_CACK) begin
            drive_low <= dir_rd && !rd_byte[7];
         end else if (st == cea_pkg::S_TX) begin
            drive_low <= (cnt != cea_pkg::TX_LAST) && !tx[6];
         end else if (st == cea_pkg::S_MACK) begin
            drive_low <= !rd_byte[7];
         end else begin
            drive_low <= 1'b0;
         end
      end
   end

   // line changes only after a hold past the clock fall, except at start or stop, which release it at once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_n <= 1'b1;
         hold_cnt <= '0;
      end else if (start || stop) begin
         sda_oe_n <= 1'b1;
         hold_cnt <= '0;
      end else if (scl_fall) begin
         hold_cnt <= HCW'(cea_pkg::OUT_HOLD_CYC);
      end else if (hold_cnt != '0) begin
         hold_cnt <= hold_cnt - 1'b1;
         if (hold_cnt == HCW'(1)) begin
            sda_oe_n <= !drive_low;
         end
      end
   end

   cea_fifo2 #(
      .W (cea_pkg::FIFO_W)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (wpush),
      .in_ready  (f_in_ready),
      .in_data   ({ptr, rx}),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // page buffer stalls its drain while a commit runs
   assign f_out_ready = (cstate == cea_pkg::C_IDLE);
   assign has_data    = (|pg_valid) || f_out_valid;

   always_ff @(posedge sys_clk) begin
      if (f_out_valid && f_out_ready) begin
         pg_data[f_out_data[8 +: cea_pkg::PAGE_W]] <= f_out_data[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pg_valid <= '0;
         pg_high  <= '0;
      end else if (f_out_valid && f_out_ready) begin
         pg_valid[f_out_data[8 +: cea_pkg::PAGE_W]] <= 1'b1;
         pg_high <= f_out_data[cea_pkg::FIFO_W-1 -: (AW - cea_pkg::PAGE_W)];
      end else if (cstate == cea_pkg::C_COPY) begin
         pg_valid[idx] <= 1'b0;
      end else if (start && !busy) begin
         // page abandoned without a stop is dropped
         pg_valid <= '0;
      end
   end

   // commit sequencer: copy page, then hold off for the write time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         commit_req <= 1'b0;
      end else if (stop && has_data) begin
         commit_req <= 1'b1;
      end else if (cstate == cea_pkg::C_IDLE && !f_out_valid) begin
         commit_req <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cstate   <= cea_pkg::C_IDLE;
         idx      <= cea_pkg::CNT_RST;
         wait_cnt <= '0;
      end else begin
         unique case (cstate)
            cea_pkg::C_IDLE: begin
               if (commit_req && !f_out_valid) begin
                  cstate <= cea_pkg::C_COPY;
                  idx    <= cea_pkg::CNT_RST;
               end
            end
            cea_pkg::C_COPY: begin
               idx <= idx + 4'h1;
               if (idx == cea_pkg::PG_LAST) begin
                  cstate   <= cea_pkg::C_WAIT;
                  wait_cnt <= WCW'(WRITE_CYCLES - 1);
               end
            end
            cea_pkg::C_WAIT: begin
               wait_cnt <= wait_cnt - 1'b1;
               if (wait_cnt == '0) begin
                  cstate <= cea_pkg::C_IDLE;
               end
            end
            default: cstate <= cea_pkg::C_IDLE;
         endcase
      end
   end

   // storage array and its read port
   always_ff @(posedge sys_clk) begin
      if (cstate == cea_pkg::C_COPY && pg_valid[idx]) begin
         mem[{pg_high, idx}] <= pg_data[idx];
      end
      rd_byte <= mem[ptr];
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_stop_data;
      stop && has_data && !busy;
   endsequence

   sequence s_copy_start;
      ##[1:3] (cstate == cea_pkg::C_COPY);
   endsequence

   a_ctrl_first: assert property (start |=> st == cea_pkg::S_CTRL && cnt == '0)
      else $error("start did not open a control byte");
   a_code_reject: assert property ((st == cea_pkg::S_CTRL && rx_done &&
      rx[7:4] != 4'hA) |=> st == cea_pkg::S_SKIP ##1 sda_oe_n)
      else $error("wrong control code was answered");
   a_block_ignored: assert property ((st == cea_pkg::S_CTRL && rx_done && !busy &&
      rx[7:4] == 4'hA) |=> st == cea_pkg::S_CACK)
      else $error("matching control byte not accepted");
   a_dir_read: assert property ((st == cea_pkg::S_CACK && scl_fall && dir_rd) |=>
      st == cea_pkg::S_TX && tx == $past(rd_byte))
      else $error("read direction did not start a byte");
   a_addr_load: assert property ((st == cea_pkg::S_ADDR && rx_done) |=>
      ptr == {1'b0, $past(rx)})
      else $error("word address not loaded");
   a_busy_silent: assert property (busy |-> sda_oe_n)
      else $error("line driven during write cycle");
   a_commit_start: assert property (s_stop_data |-> s_copy_start)
      else $error("stop did not start the commit");
   a_page_wrap: assert property (wpush |=> ptr[3:0] == $past(ptr[3:0]) + 4'h1 &&
      ptr[8:4] == $past(ptr[8:4]))
      else $error("page pointer step wrong");
   a_read_incr: assert property (tx_done |=> ptr == $past(ptr) + 9'h001)
      else $error("pointer not bumped after read byte");
   a_ack_ninth: assert property ((scl_rise && (st == cea_pkg::S_AACK ||
      st == cea_pkg::S_WACK)) |-> !sda_oe_n)
      else $error("ninth clock without acknowledge");
   a_stop_release: assert property (stop |=> sda_oe_n && st == cea_pkg::S_IDLE)
      else $error("line held after stop");
   a_mack_next: assert property ((st == cea_pkg::S_MACK && scl_fall && !start && !stop)
      |=> st == cea_pkg::S_TX && tx == $past(rd_byte))
      else $error("master ack did not fetch next byte");
endmodule // cea_eeprom

// ===== logic/cea_pkg.sv
// shared constants and types of the calibration memory access block
package cea_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int WR_TIME_MS    = 10;
   // longest time, so rounded down
   localparam int WR_CYCLES     = WR_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int WR_CNT_W      = 22;
   localparam int OUT_HOLD_NS   = 300;
   // least time, so rounded up
   localparam int OUT_HOLD_CYC  = (OUT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W    = 7;

   // control byte
   localparam logic [3:0] CTRL_CODE = 4'hA;
   localparam int         CODE_MSB  = 7;
   localparam int         CODE_LSB  = 4;
   localparam int         DIR_BIT   = 0;

   // memory geometry
   localparam int ADDR_W     = 9;
   localparam int MEM_BYTES  = 512;
   localparam int PAGE_W     = 4;
   localparam int PAGE_BYTES = 16;
   localparam int FIFO_W     = ADDR_W + 8;

   // bit counting
   localparam logic [3:0] RX_LAST  = 4'h8;
   localparam logic [3:0] TX_LAST  = 4'h7;
   localparam logic [3:0] CNT_RST  = 4'h0;
   localparam logic [3:0] PG_LAST  = 4'hF;

   // values after reset
   localparam logic [ADDR_W-1:0] PTR_RST  = 9'h000;
   localparam logic [7:0]        BYTE_RST = 8'h00;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_CTRL = 4'h1,
      S_CACK = 4'h2,
      S_ADDR = 4'h3,
      S_AACK = 4'h4,
      S_WDAT = 4'h5,
      S_WACK = 4'h6,
      S_TX   = 4'h7,
      S_MACK = 4'h8,
      S_SKIP = 4'h9
   } cea_bus_t;

   typedef enum logic [1:0] {
      C_IDLE = 2'h0,
      C_COPY = 2'h1,
      C_WAIT = 2'h2
   } cea_commit_t;
endpackage

// ===== logic/cea_sync.sv
// two-flop synchronisers for the bus pins
module cea_sync #(
   parameter int N = 2
) (
   input  wire logic         sys_clk, // system clock
   input  wire logic         rst_n,   // async reset, active low
   input  wire logic [N-1:0] d,       // raw pin levels
   output logic      [N-1:0] q        // synchronised levels
);
   logic [N-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         // idle bus lines sit high
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta[i] <= 1'b1;
               q[i]    <= 1'b1;
            end else begin
               meta[i] <= d[i];
               q[i]    <= meta[i];
            end
         end
      end
   endgenerate
endmodule // cea_sync

// ===== logic/cea_fifo2.sv
// two-entry buffer with valid and ready on both sides
module cea_fifo2 #(
   parameter int W = 17
) (
   input  wire logic         sys_clk,   // system clock
   input  wire logic         rst_n,     // async reset, active low
   input  wire logic         in_valid,  // word offered
   output logic              in_ready,  // room for a word
   input  wire logic [W-1:0] in_data,   // word in
   output logic              out_valid, // word available
   input  wire logic         out_ready, // drain side accepts
   output logic      [W-1:0] out_data   // oldest word
);
   logic [W-1:0] slot [2];
   logic         wr_sel;
   logic         rd_sel;
   logic [1:0]   fill;
   logic         push;
   logic         pop;

   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = slot[rd_sel];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         slot[wr_sel] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_sel <= 1'b0;
         rd_sel <= 1'b0;
         fill   <= 2'h0;
      end else begin
         if (push) begin
            wr_sel <= !wr_sel;
         end
         if (pop) begin
            rd_sel <= !rd_sel;
         end
         fill <= fill + 2'(push) - 2'(pop);
      end
   end
endmodule // cea_fifo2

// ===== sim/cea_host.sv
// two-wire bus master model for the calibration memory
module cea_host (
   input  wire logic sys_clk, // system clock
   input  wire logic sda,     // resolved data line level
   output logic      scl,     // bus clock from the master
   output logic      sda_m    // master data drive, 1 releases
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // data moves only while the clock is low; low phase outlasts the device hold
   task automatic put_bit(input logic b, output logic r);
      tick(10);
      sda_m <= b;
      tick(70);
      scl <= 1'b1;
      tick(20);
      r = sda;
      tick(20);
      scl <= 1'b0;
   endtask

   // also serves as repeated start from a low clock
   task automatic start();
      tick(10);
      sda_m <= 1'b1;
      tick(70);
      scl <= 1'b1;
      tick(40);
      sda_m <= 1'b0;
      tick(40);
      scl <= 1'b0;
   endtask

   task automatic stop();
      tick(10);
      sda_m <= 1'b0;
      tick(70);
      scl <= 1'b1;
      tick(40);
      sda_m <= 1'b1;
      tick(40);
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'b1, r);
      ack = (r === 1'b0);
   endtask

   // first byte after a start: code, block select, direction
   task automatic ctrl(input logic rd, input logic [2:0] blk, output logic ack);
      send_byte({4'hA, blk, rd}, ack);
   endtask

   // master ack asks for more, no ack ends the read
   task automatic recv_byte(input logic give_ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         d[i] = r;
      end
      put_bit(~give_ack, r);
   endtask
endmodule // cea_host

// ===== sim/cea_eeprom_bench.sv
// self-checking bench of the calibration memory slave
module cea_eeprom_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WR_CYC = 3000;
   // stored data layout seen by the host
   localparam int POS_REF   = 1;   // reference data, 256 bytes
   localparam int POS_DRIVE = 292; // light drive setting
   localparam int POS_INTEG = 293; // integration time
   localparam int POS_FACT  = 296; // factory points, 4 bytes each
   localparam int POS_USER  = 308; // user points, 4 bytes each
   localparam int POS_MODEL = 262; // 10-byte model id
   localparam int POS_ID    = 272; // 20-byte date and serial id

   logic       sys_clk;
   logic       rst_n;
   logic       scl;
   logic       sda_m;
   logic       sda_out;
   logic       sda_oe_n;
   logic       wr_busy;
   logic       sda;
   logic       a;
   logic [7:0] d;
   logic [7:0] pg [16];
   int         n_mismatch;
   int         check_count;

   // wired-and with pull-up
   assign sda = sda_m & (sda_oe_n | sda_out);

   cea_eeprom #(.WRITE_CYCLES(WR_CYC)) dut_u (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .scl_in   (scl),
      .sda_in   (sda),
      .sda_out  (sda_out),
      .sda_oe_n (sda_oe_n),
      .wr_busy  (wr_busy)
   );

   cea_host host_u (
      .sys_clk (sys_clk),
      .sda     (sda),
      .scl     (scl),
      .sda_m   (sda_m)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wait_idle();
      int i;
      for (i = 0; i < 10000 && wr_busy !== 1'b0; i++) @(posedge sys_clk);
      if (i == 10000) begin
         n_mismatch++;
         $display("MISMATCH t=%0t write cycle never ends", $time);
         stop_test();
      end
   endtask

   // byte write with odd block bits, then a read refused while busy
   task automatic t_byte_write();
      host_u.start();
      host_u.ctrl(1'b0, 3'h5, a);
      check({7'h0, a}, 8'h01, "ctrl ack");
      host_u.send_byte(8'h20, a);
      check({7'h0, a}, 8'h01, "addr ack");
      host_u.send_byte(8'hC3, a);
      check({7'h0, a}, 8'h01, "data ack");
      host_u.stop();
      check({7'h0, wr_busy}, 8'h01, "busy after stop");
      host_u.start();
      host_u.ctrl(1'b1, 3'h0, a);
      check({7'h0, a}, 8'h00, "ack while busy");
      host_u.stop();
      wait_idle();
   endtask

   // 18 bytes into one page: low bits wrap, first two overwritten
   task automatic t_page_write();
      host_u.start();
      host_u.ctrl(1'b0, 3'h0, a);
      host_u.send_byte(8'h1E, a);
      for (int i = 0; i < 18; i++) begin
         host_u.send_byte(8'h30 + 8'(i), a);
         check({7'h0, a}, 8'h01, "page data ack");
         pg[(14 + i) % 16] = 8'h30 + 8'(i);
      end
      host_u.stop();
      check({7'h0, wr_busy}, 8'h01, "busy after page");
      wait_idle();
   endtask

   // random read into a sequential read crossing the page end
   task automatic t_seq_read();
      host_u.start();
      host_u.ctrl(1'b0, 3'h0, a);
      host_u.send_byte(8'h1E, a);
      host_u.start();
      host_u.ctrl(1'b1, 3'h0, a);
      check({7'h0, a}, 8'h01, "read ctrl ack");
      host_u.recv_byte(1'b1, d);
      check(d, pg[14], "seq byte 0");
      host_u.recv_byte(1'b1, d);
      check(d, pg[15], "seq byte 1");
      host_u.recv_byte(1'b0, d);
      check(d, 8'hC3, "seq byte 2");
      host_u.stop();
      check({7'h0, sda_oe_n}, 8'h01, "release at stop");
   endtask

   // random read then current address read
   task automatic t_cur_read();
      host_u.start();
      host_u.ctrl(1'b0, 3'h0, a);
      host_u.send_byte(8'h10, a);
      host_u.start();
      host_u.ctrl(1'b1, 3'h0, a);
      host_u.recv_byte(1'b0, d);
      check(d, pg[0], "random read");
      host_u.stop();
      host_u.start();
      host_u.ctrl(1'b1, 3'h7, a);
      check({7'h0, a}, 8'h01, "current ctrl ack");
      host_u.recv_byte(1'b0, d);
      check(d, pg[1], "current read");
      host_u.stop();
   endtask

   // byte at the start of the reference region written and read back
   task automatic t_layout();
      host_u.start();
      host_u.ctrl(1'b0, 3'h0, a);
      host_u.send_byte(8'(POS_REF), a);
      host_u.send_byte(8'h5A, a);
      check({7'h0, a}, 8'h01, "ref data ack");
      host_u.stop();
      wait_idle();
      host_u.start();
      host_u.ctrl(1'b0, 3'h0, a);
      host_u.send_byte(8'(POS_REF), a);
      host_u.start();
      host_u.ctrl(1'b1, 3'h0, a);
      host_u.recv_byte(1'b0, d);
      check(d, 8'h5A, "ref first byte");
      host_u.stop();
   endtask

   // wrong code, then a good code without start stays ignored
   task automatic t_bad_code();
      host_u.start();
      host_u.send_byte(8'hB1, a);
      check({7'h0, a}, 8'h00, "bad code ack");
      host_u.send_byte(8'hA1, a);
      check({7'h0, a}, 8'h00, "ignored till start");
      host_u.stop();
      check({7'h0, wr_busy}, 8'h00, "no write on bad code");
   endtask

   initial begin
      n_mismatch = 0;
      check_count = 0;
      rst_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check({7'h0, sda_oe_n}, 8'h01, "idle release");
      check({7'h0, sda_out}, 8'h00, "drive level low");
      t_byte_write();
      t_page_write();
      t_seq_read();
      t_cur_read();
      t_layout();
      t_bad_code();
      stop_test();
   end
endmodule // cea_eeprom_bench
